/* ser_pkg.sv */
package ser_pkg;
	localparam int SER_ADDR_W = 8;
	localparam int SER_DATA_W = 32;

	// Register byte offsets; the high word sits directly above the low word.
	localparam logic [7:0] SER_OFF_WORD_LOW = 8'h00;
	localparam logic [7:0] SER_OFF_WORD_HIGH = 8'h04;
	localparam logic [7:0] SER_OFF_CAPTURE = 8'h08;
	localparam logic [7:0] SER_OFF_TIMER_LATCH = 8'h0c;
	localparam logic [7:0] SER_OFF_CTRL = 8'h10;
	localparam logic [7:0] SER_OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] SER_OFF_IRQ_ENABLE = 8'h18;
	localparam logic [7:0] SER_OFF_IRQ_CLEAR = 8'h1c;
	localparam logic [7:0] SER_OFF_ERROR = 8'h20;

	// Result word field positions.
	localparam int SER_ST_W = 17;
	localparam int SER_MT_LO_LSB = 24;
	localparam int SER_TIMEOUT_BIT = 31;
	localparam int SER_FINE_W = 21;
	localparam int SER_DIGITS = 5;
	localparam logic [7:0] SER_ASCII_ZERO = 8'h30;
	localparam logic [7:0] SER_ASCII_MINUS = 8'h2d;
	localparam logic [7:0] SER_ASCII_PLUS = 8'h2b;

	// Control register layout and reset value.
	localparam int SER_CTRL_MODE_LSB = 0;
	localparam int SER_CTRL_CAPT_BIT = 2;
	localparam int SER_CTRL_W = 3;
	localparam logic [2:0] SER_CTRL_RST = 3'h0;

	// Interrupt event bit positions.
	localparam int SER_EV_UPDATE = 0;
	localparam int SER_EV_TIMEOUT = 1;
	localparam int SER_EV_ERROR = 2;
	localparam int SER_EV_TRIGGER = 3;
	localparam int SER_EV_W = 4;
	localparam logic [3:0] SER_EV_RST = 4'h0;

	// Error register bit positions.
	localparam int SER_ERR_PARITY = 0;
	localparam int SER_ERR_CRC = 1;

	// Response watchdog timing.
	localparam int SER_CLK_PERIOD_NS = 8;
	localparam int SER_RESP_TIMEOUT_NS = 20000;
	localparam int SER_RESP_TIMEOUT_CYC =
		(SER_RESP_TIMEOUT_NS + SER_CLK_PERIOD_NS - 1) / SER_CLK_PERIOD_NS;
	localparam int SER_WD_W = 12;

	typedef enum logic [1:0] {
		SER_MODE_SPLIT = 2'h0,
		SER_MODE_QUAD_ASCII = 2'h1,
		SER_MODE_PARITY_LOSS = 2'h2,
		SER_MODE_CRC_LOSS = 2'h3
	} ser_mode_t;

	typedef enum logic [0:0] {
		SER_WD_IDLE = 1'b0,
		SER_WD_WAIT = 1'b1
	} ser_wd_state_t;
endpackage : ser_pkg

/* ser_watchdog.sv */
`timescale 1ns/1ps
module ser_watchdog
	import ser_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic resp,
	output logic busy,
	output logic timeout
);
	ser_wd_state_t state_ff;
	ser_wd_state_t nxt_state;
	logic [SER_WD_W-1:0] cnt_ff;
	logic [SER_WD_W-1:0] nxt_cnt;
	logic expired;
	logic timeout_ff;

	assign expired = (cnt_ff == SER_WD_W'(SER_RESP_TIMEOUT_CYC - 1));
	assign busy = (state_ff == SER_WD_WAIT);
	assign timeout = timeout_ff;

	// A new request restarts the wait even if the last one is still open.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		unique case (state_ff)
			SER_WD_IDLE:
			begin
				if (start)
				begin
					nxt_state = SER_WD_WAIT;
					nxt_cnt = '0;
				end
			end
			SER_WD_WAIT:
			begin
				nxt_cnt = cnt_ff + 1'b1;
				if (start)
					nxt_cnt = '0;
				else if (resp || expired)
					nxt_state = SER_WD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state_ff <= SER_WD_IDLE;
			cnt_ff <= '0;
			timeout_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			timeout_ff <= busy && expired && !resp && !start;
		end
	end
endmodule : ser_watchdog

/* ser_result_regs.sv */
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Split protocols put single-turn position in bits 0..16 of the low word.
// - Multi-turn low byte in low word 31..24, high byte in high word 7..0.
// - Quadrature protocol: capture register holds position in 1/256 counts, 8192 counts/rev.
// - Quadrature protocol: turns digits stored as ASCII, digit value plus 48.
// - Position refreshes once per cycle; no hardware position capture on trigger.
// - A request without encoder answer sets the channel timeout flag.
// - Timeout flag is high-true bit 31 of the high word where supported.
// - Protocols without timeout flag set parity or CRC error on no answer.
// - Trigger latches a free-running timer for software interpolation.
// - High word sits at the address directly above the low word.
module ser_result_regs
	import ser_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [ser_pkg::SER_ADDR_W-1:0] addr,
	input wire logic [ser_pkg::SER_DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [ser_pkg::SER_DATA_W-1:0] rd_data,
	input wire logic cycle_clk_pin,
	input wire logic trigger_pin,
	output logic enc_req,
	input wire logic rx_valid,
	input wire logic [ser_pkg::SER_ST_W-1:0] rx_single_turn,
	input wire logic [15:0] rx_multi_turn,
	input wire logic [ser_pkg::SER_FINE_W-1:0] rx_fine_pos,
	input wire logic [19:0] rx_turns_digits,
	input wire logic rx_turns_neg,
	input wire logic rx_parity_err,
	input wire logic rx_crc_err,
	output logic irq
);
	import ser_pkg::*;

	logic cyc_s1_ff, cyc_s2_ff, cyc_d_ff;
	logic trg_s1_ff, trg_s2_ff, trg_d_ff;
	logic enc_req_ff;
	logic [31:0] word_low_ff, word_high_ff, capt_ff, timer_ff, tlatch_ff;
	logic [SER_CTRL_W-1:0] ctrl_ff;
	logic [SER_EV_W-1:0] status_ff, enable_ff;
	logic [1:0] err_ff;
	logic irq_ff;
	logic [31:0] rd_data_ff;

	logic cycle_start, trig_edge, wd_busy, wd_timeout, accept, update;
	ser_mode_t mode;
	logic capt_en, mode_quad, mode_has_tmo;
	logic [31:0] split_low, split_high, asc_low, asc_high;
	logic [31:0] nxt_word_low, nxt_word_high, nxt_rd_data;
	logic [1:0] nxt_err;
	logic [7:0] asc_digit [SER_DIGITS];
	logic [SER_EV_W-1:0] events, clr_bits, nxt_status;
	logic wr_ctrl, wr_enable, wr_clear, err_set;

	assign cycle_start = cyc_s2_ff && !cyc_d_ff;
	assign trig_edge = trg_s2_ff && !trg_d_ff;
	assign mode = ser_mode_t'(ctrl_ff[SER_CTRL_MODE_LSB +: 2]);
	assign capt_en = ctrl_ff[SER_CTRL_CAPT_BIT];
	assign mode_quad = (mode == SER_MODE_QUAD_ASCII);
	assign mode_has_tmo = (mode == SER_MODE_SPLIT) || mode_quad;

	ser_watchdog u_watchdog (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(cycle_start),
		.resp(rx_valid),
		.busy(wd_busy),
		.timeout(wd_timeout)
	);

	// Only an answer to an outstanding request counts; stray frames are dropped.
	assign accept = rx_valid && wd_busy;
	assign update = accept || wd_timeout;

	assign split_low = {rx_multi_turn[7:0], 7'h00, rx_single_turn};
	assign split_high = {8'h00, 8'h00, 8'h00, rx_multi_turn[15:8]};

	genvar gi;
	generate
		for (gi = 0; gi < SER_DIGITS; gi++)
		begin : g_ascii
			assign asc_digit[gi] = {4'h0, rx_turns_digits[4*gi +: 4]} + SER_ASCII_ZERO;
		end
	endgenerate
	assign asc_low = {asc_digit[3], asc_digit[2], asc_digit[1], asc_digit[0]};
	assign asc_high = {16'h0000, (rx_turns_neg ? SER_ASCII_MINUS : SER_ASCII_PLUS),
		asc_digit[4]};

	// On a timeout the position stays as last received; only the flag moves.
	assign nxt_word_low = !accept ? word_low_ff : (mode_quad ? asc_low : split_low);
	assign nxt_word_high = {wd_timeout && mode_has_tmo,
		(!accept ? word_high_ff[30:0] : (mode_quad ? asc_high[30:0] : split_high[30:0]))};

	assign nxt_err = accept ? {rx_crc_err, rx_parity_err} :
		{mode == SER_MODE_CRC_LOSS, mode == SER_MODE_PARITY_LOSS};
	assign err_set = update && (nxt_err != 2'h0);

	assign wr_ctrl = wr_en && (addr == SER_OFF_CTRL);
	assign wr_enable = wr_en && (addr == SER_OFF_IRQ_ENABLE);
	assign wr_clear = wr_en && (addr == SER_OFF_IRQ_CLEAR);
	assign clr_bits = wr_clear ? wr_data[SER_EV_W-1:0] : SER_EV_RST;
	assign events = {trig_edge && capt_en, err_set, wd_timeout, accept};
	// A new event wins over a clear written in the same cycle.
	assign nxt_status = (status_ff & ~clr_bits) | events;

	always_comb
	begin
		nxt_rd_data = 32'h0000_0000;
		unique case (addr)
			SER_OFF_WORD_LOW: nxt_rd_data = word_low_ff;
			SER_OFF_WORD_HIGH: nxt_rd_data = word_high_ff;
			SER_OFF_CAPTURE: nxt_rd_data = capt_ff;
			SER_OFF_TIMER_LATCH: nxt_rd_data = tlatch_ff;
			SER_OFF_CTRL: nxt_rd_data = {29'h0, ctrl_ff};
			SER_OFF_IRQ_STATUS: nxt_rd_data = {28'h0, status_ff};
			SER_OFF_IRQ_ENABLE: nxt_rd_data = {28'h0, enable_ff};
			SER_OFF_ERROR: nxt_rd_data = {30'h0, err_ff};
			default: nxt_rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			cyc_s1_ff <= 1'b0;
			cyc_s2_ff <= 1'b0;
			cyc_d_ff <= 1'b0;
			trg_s1_ff <= 1'b0;
			trg_s2_ff <= 1'b0;
			trg_d_ff <= 1'b0;
			enc_req_ff <= 1'b0;
		end
		else
		begin
			cyc_s1_ff <= cycle_clk_pin;
			cyc_s2_ff <= cyc_s1_ff;
			cyc_d_ff <= cyc_s2_ff;
			trg_s1_ff <= trigger_pin;
			trg_s2_ff <= trg_s1_ff;
			trg_d_ff <= trg_s2_ff;
			enc_req_ff <= cycle_start;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			word_low_ff <= 32'h0000_0000;
			word_high_ff <= 32'h0000_0000;
			capt_ff <= 32'h0000_0000;
			err_ff <= 2'h0;
		end
		else if (update)
		begin
			word_low_ff <= nxt_word_low;
			word_high_ff <= nxt_word_high;
			err_ff <= nxt_err;
			if (accept && mode_quad)
				capt_ff <= {11'h000, rx_fine_pos};
		end
	end

	// The trigger never snapshots the position words; the timer stamp lets
	// software interpolate between the once-per-cycle positions instead.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			timer_ff <= 32'h0000_0000;
			tlatch_ff <= 32'h0000_0000;
		end
		else
		begin
			timer_ff <= timer_ff + 32'h0000_0001;
			if (trig_edge && capt_en)
				tlatch_ff <= timer_ff;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			ctrl_ff <= SER_CTRL_RST;
			enable_ff <= SER_EV_RST;
			status_ff <= SER_EV_RST;
			irq_ff <= 1'b0;
			rd_data_ff <= 32'h0000_0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_ff <= wr_data[SER_CTRL_W-1:0];
			if (wr_enable)
				enable_ff <= wr_data[SER_EV_W-1:0];
			status_ff <= nxt_status;
			irq_ff <= |(nxt_status & (wr_enable ? wr_data[SER_EV_W-1:0] : enable_ff));
			rd_data_ff <= rd_en ? nxt_rd_data : 32'h0000_0000;
		end
	end

	assign rd_data = rd_data_ff;
	assign enc_req = enc_req_ff;
	assign irq = irq_ff;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_split_accept;
		accept && (mode == SER_MODE_SPLIT);
	endsequence

	sequence s_quad_accept;
		accept && mode_quad;
	endsequence

	sequence s_lost_answer;
		wd_timeout;
	endsequence

	sequence s_trig_taken;
		trig_edge && capt_en;
	endsequence

	// Apart from a_high_read and a_low_read, which check rd_data_ff, the checks look at the registers one edge after the cause,
	// so a failure points at the update logic and not at the read path.
	a_req_after_edge: assert property (cycle_start |=> enc_req_ff ##1 !enc_req_ff)
		else $error("request pulse not issued once per cycle edge");
	a_req_source: assert property (enc_req_ff |-> $past(cycle_start))
		else $error("request without cycle edge");

	a_single_turn: assert property (s_split_accept |=>
		word_low_ff[16:0] == $past(rx_single_turn) && word_low_ff[23:17] == 7'h00)
		else $error("single-turn field wrong");
	a_multi_turn: assert property (s_split_accept |=>
		word_low_ff[31:24] == $past(rx_multi_turn[7:0]) &&
		word_high_ff[7:0] == $past(rx_multi_turn[15:8]))
		else $error("multi-turn split wrong");
	a_split_pad: assert property (s_split_accept |=> word_high_ff[30:8] == 23'h000000)
		else $error("split high word not padded");

	a_fine_capture: assert property (s_quad_accept |=>
		capt_ff == {11'h000, $past(rx_fine_pos)})
		else $error("capture register not loaded");
	a_split_no_capt: assert property (accept && !mode_quad |=> $stable(capt_ff))
		else $error("capture register moved outside quadrature mode");

	a_ascii_digit: assert property (s_quad_accept |=>
		word_low_ff[15:8] == SER_ASCII_ZERO + {4'h0, $past(rx_turns_digits[7:4])})
		else $error("ascii digit encoding wrong");
	a_ascii_ones: assert property (s_quad_accept |=>
		word_low_ff[7:0] == SER_ASCII_ZERO + {4'h0, $past(rx_turns_digits[3:0])})
		else $error("ascii ones digit wrong");
	a_ascii_top: assert property (s_quad_accept |=>
		word_high_ff[7:0] == SER_ASCII_ZERO + {4'h0, $past(rx_turns_digits[19:16])})
		else $error("ascii top digit wrong");
	a_ascii_sign: assert property (s_quad_accept |=>
		word_high_ff[15:8] == ($past(rx_turns_neg) ? SER_ASCII_MINUS : SER_ASCII_PLUS))
		else $error("turns sign byte wrong");

	a_trig_no_pos: assert property (trig_edge && !update |=>
		$stable(word_low_ff) && $stable(word_high_ff) && $stable(capt_ff))
		else $error("trigger moved the position words");

	a_timeout_flag: assert property (wd_timeout && mode_has_tmo |=>
		word_high_ff[31] ##1 word_high_ff[31] || $past(update))
		else $error("timeout flag not set");
	a_timeout_event: assert property (s_lost_answer |=> status_ff[SER_EV_TIMEOUT])
		else $error("timeout event not recorded");
	a_timeout_pos: assert property (s_lost_answer |=> $stable(word_low_ff))
		else $error("position moved on timeout");
	a_answer_clears: assert property (accept |=> !word_high_ff[31])
		else $error("timeout flag stuck after answer");
	a_tmo_supported: assert property (update && !mode_has_tmo |=> !word_high_ff[31])
		else $error("timeout flag set in a mode without it");

	a_parity_loss: assert property (wd_timeout && mode == SER_MODE_PARITY_LOSS |=>
		err_ff == 2'h1 && !word_high_ff[31])
		else $error("parity loss not reported");
	a_crc_loss: assert property (wd_timeout && mode == SER_MODE_CRC_LOSS |=>
		err_ff == 2'h2 && !word_high_ff[31])
		else $error("crc loss not reported");
	a_err_from_frame: assert property (accept |=>
		err_ff == {$past(rx_crc_err), $past(rx_parity_err)})
		else $error("frame error bits not kept");

	a_timer_latch: assert property (s_trig_taken |=> tlatch_ff == $past(timer_ff))
		else $error("timer not latched on trigger");
	a_trig_event: assert property (s_trig_taken |=> status_ff[SER_EV_TRIGGER])
		else $error("trigger event not recorded");

	a_high_read: assert property (rd_en && addr == SER_OFF_WORD_LOW + 8'h04 |=>
		rd_data_ff == $past(word_high_ff))
		else $error("high word not at next address");
	a_low_read: assert property (rd_en && addr == SER_OFF_WORD_LOW |=>
		rd_data_ff == $past(word_low_ff))
		else $error("low word read wrong");

	a_update_event: assert property (accept |=> status_ff[SER_EV_UPDATE])
		else $error("update event not recorded");
	a_hold_words: assert property (!update |=>
		$stable(word_low_ff) && $stable(word_high_ff) && $stable(err_ff))
		else $error("result changed without update");
endmodule : ser_result_regs

/* ser_enc_model.sv */
`timescale 1ns/1ps
module ser_enc_model (
	input wire logic clk_sys,
	input wire logic enc_req,
	input wire logic silent,
	input wire logic [3:0] dly,
	input wire logic [63:0] frame,
	output logic rx_valid,
	output logic [63:0] rx_bus
);
	logic [4:0] cnt_ff;

	initial
	begin
		cnt_ff = 5'h0;
		rx_valid = 1'b0;
	end

	// A request is answered dly+1 cycles after the edge that samples it; a silent encoder never answers.
	always @(posedge clk_sys)
	begin
		rx_valid <= 1'b0;
		if (enc_req && !silent)
			cnt_ff <= {1'b0, dly} + 5'h1;
		else if (cnt_ff != 5'h0)
		begin
			cnt_ff <= cnt_ff - 5'h1;
			rx_valid <= (cnt_ff == 5'h1);
		end
	end

	// Outside a frame the lines show the inverse, so stale data cannot pass for a frame.
	assign rx_bus = rx_valid ? frame : ~frame;
endmodule : ser_enc_model

/* test_serial_encoder_result_regs.sv */
`timescale 1ns/1ps
module test_serial_encoder_result_regs;
	import ser_pkg::*;
	logic clk_sys, rst_n, wr_en, rd_en, cyc_pin, trig_pin, silent, irq, enc_req, rx_valid;
	logic [7:0] addr;
	logic [31:0] wr_data, rd_data, got, lat_a, t_a, t_b, clk_cnt, req_cnt;
	logic [63:0] frame, rx_bus;
	logic [3:0] dly;
	int num_errors, checked;

	ser_result_regs u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .cycle_clk_pin(cyc_pin),
		.trigger_pin(trig_pin), .enc_req(enc_req), .rx_valid(rx_valid),
		.rx_single_turn(rx_bus[16:0]), .rx_multi_turn(rx_bus[32:17]),
		.rx_fine_pos(rx_bus[20:0]), .rx_turns_digits(rx_bus[40:21]),
		.rx_turns_neg(rx_bus[41]), .rx_parity_err(rx_bus[42]),
		.rx_crc_err(rx_bus[43]), .irq(irq));
	ser_enc_model u_enc (.clk_sys(clk_sys), .enc_req(enc_req), .silent(silent), .dly(dly),
		.frame(frame), .rx_valid(rx_valid), .rx_bus(rx_bus));

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) clk_cnt <= clk_cnt + 32'h1;

	// Counts request pulses so that each cycle edge is seen to ask exactly once.
	always @(posedge clk_sys)
		if (enc_req === 1'b1)
			req_cnt <= req_cnt + 32'h1;

	task automatic results();
		if (num_errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp)
		begin
			$display("wrong value %s expected %h seen %h", n, exp, seen);
			num_errors++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1;
		got = rd_data;
	endtask : rd

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(n, exp, got);
	endtask : rdc

	// Raises a pin for a few cycles, then waits for the resulting interrupt.
	task automatic pulse(input bit trig);
		int n;
		@(posedge clk_sys);
		if (trig)
			trig_pin <= 1'b1;
		else
			cyc_pin <= 1'b1;
		t_a = clk_cnt;
		repeat (4) @(posedge clk_sys);
		trig_pin <= 1'b0;
		cyc_pin <= 1'b0;
		n = 0;
		while (irq !== 1'b1 && n < 4000)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 4000)
		begin
			chk("irq wait", 32'h1, {31'h0, irq});
			results();
		end
	endtask : pulse

	initial
	begin
		rst_n = 1'b0;
		{wr_en, rd_en, cyc_pin, trig_pin, silent} = 5'h0;
		addr = 8'h0;
		wr_data = 32'h0;
		dly = 4'h9;
		clk_cnt = 32'h0;
		req_cnt = 32'h0;
		num_errors = 0;
		checked = 0;
		frame = {31'h0, 16'h5a3c, 17'h1abcd};
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdc("ctrl", SER_OFF_CTRL, 32'h0);
		rdc("unmapped", 8'h24, 32'h0);
		wr(SER_OFF_WORD_LOW, 32'hffffffff);
		rdc("low ro", SER_OFF_WORD_LOW, 32'h0);
		wr(SER_OFF_IRQ_ENABLE, 32'hf);
		pulse(0);
		rdc("low split", SER_OFF_WORD_LOW, 32'h3c01abcd);
		rdc("high split", SER_OFF_WORD_HIGH, 32'h0000005a);
		rdc("status", SER_OFF_IRQ_STATUS, 32'h1);
		wr(SER_OFF_IRQ_CLEAR, 32'hf);
		chk("irq", 32'h0, {31'h0, irq});
		silent = 1'b1;
		pulse(0);
		rdc("high lost", SER_OFF_WORD_HIGH, 32'h8000005a);
		rdc("low held", SER_OFF_WORD_LOW, 32'h3c01abcd);
		rdc("status lost", SER_OFF_IRQ_STATUS, 32'h2);
		wr(SER_OFF_IRQ_CLEAR, 32'hf);
		wr(SER_OFF_CTRL, 32'h2);
		pulse(0);
		rdc("parity", SER_OFF_ERROR, 32'h1);
		rdc("high parity", SER_OFF_WORD_HIGH, 32'h0000005a);
		wr(SER_OFF_IRQ_CLEAR, 32'hf);
		wr(SER_OFF_CTRL, 32'h3);
		pulse(0);
		rdc("crc", SER_OFF_ERROR, 32'h2);
		wr(SER_OFF_IRQ_CLEAR, 32'hf);
		silent = 1'b0;
		dly = 4'h0;
		frame = {22'h0, 1'b1, 20'h91827, 21'h1abcde};
		wr(SER_OFF_CTRL, 32'h1);
		pulse(0);
		rdc("low ascii", SER_OFF_WORD_LOW, 32'h31383237);
		rdc("high ascii", SER_OFF_WORD_HIGH, 32'h00002d39);
		rdc("capture", SER_OFF_CAPTURE, 32'h001abcde);
		rdc("error clear", SER_OFF_ERROR, 32'h0);
		wr(SER_OFF_IRQ_CLEAR, 32'hf);
		wr(SER_OFF_CTRL, 32'h5);
		pulse(1);
		rdc("status trig", SER_OFF_IRQ_STATUS, 32'h8);
		rd(SER_OFF_TIMER_LATCH);
		lat_a = got;
		t_b = t_a;
		wr(SER_OFF_IRQ_CLEAR, 32'hf);
		repeat (37) @(posedge clk_sys);
		pulse(1);
		rd(SER_OFF_TIMER_LATCH);
		chk("timer delta", t_a - t_b, got - lat_a);
		rdc("low no capture", SER_OFF_WORD_LOW, 32'h31383237);
		chk("requests", 32'h5, req_cnt);
		results();
	end
endmodule : test_serial_encoder_result_regs
